// ===== hdl/ext_bus_pin_function_mux.sv
// Pin-function multiplexer for ports P0 to P4 of the expansion bus.
// Assumes bus unit signals and pin levels are synchronous to mclk.
`timescale 1ns/1ps

module ext_bus_pin_function_mux
  import ext_bus_pin_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic processorModeInput,
  input wire logic expandEnable,
  input wire logic busWidthHigh,
  input wire logic [2:0] areaNarrow,
  input wire logic [1:0] activeArea,
  input wire port_bits_t p0GpioMask,
  input wire logic p1MuxAddr,
  input wire logic addrPhase,
  input wire logic p30ReadyOut,
  input wire logic p30Gpio,
  input wire port_bits_t p4FuncEn,
  input wire logic [4:0] dirWe,
  input wire logic [4:0] dataWe,
  input wire port_bits_t wrData,
  input wire logic [23:0] busAddr,
  input wire logic [15:0] busDataOut,
  input wire logic busDataOe,
  input wire bus_strobe_t strobes,
  input wire port_bits_t [4:0] pinIn,
  output pin_drive_t [4:0] pinDrive,
  output port_bits_t [4:0] portRead,
  output logic [15:0] busDataIn,
  output logic readyInN,
  output logic holdReqN,
  output logic accessWide,
  output mode_t modeState
);

  // ----------------------------------------------------------------------
  // Port latches
  // ----------------------------------------------------------------------
  port_bits_t [4:0] dirQ;
  port_bits_t [4:0] dataQ;

  genvar g;
  generate
    for (g = 0; g < PORT_COUNT; g++) begin : gPort
      gpio_port_regs uRegs (
        .mclk(mclk),
        .nrst(nrst),
        .dirWe(dirWe[g]),
        .dataWe(dataWe[g]),
        .wrData(wrData),
        .dirQ(dirQ[g]),
        .dataQ(dataQ[g])
      );
    end
  endgenerate

  // Selected pins take the bus level and enable; the rest keep the latches.
  function automatic pin_drive_t mergeBus(input port_bits_t dir, input port_bits_t data,
                                          input port_bits_t sel, input port_bits_t lvl,
                                          input port_bits_t oe);
    pin_drive_t r;
    r.level = (data & ~sel) | (lvl & sel);
    r.enable = (dir & ~sel) | (oe & sel);
    return r;
  endfunction : mergeBus

  // ----------------------------------------------------------------------
  // Pin assignment
  // ----------------------------------------------------------------------
  pin_drive_t [4:0] pinDrive_reg, pinDrive_next;
  port_bits_t [4:0] portRead_reg, portRead_next;
  logic [15:0] busDataIn_reg, busDataIn_next;
  logic readyInN_reg, readyInN_next;
  logic holdReqN_reg, holdReqN_next;
  logic accessWide_reg, accessWide_next;
  mode_t modeState_reg, modeState_next;

  mode_t modeNow;
  logic expanded, micro, narrowBus, muxPhase, areaIsNarrow;
  port_bits_t sel0, sel1, sel2, sel3, sel4;
  port_bits_t lvl1, oe1, lvl3, oe3, lvl4;

  always_comb begin
    // The mode pin only separates microprocessor mode from the other two.
    if (processorModeInput) begin
      modeNow = MODE_MICRO;
    end else if (expandEnable) begin
      modeNow = MODE_EXPAND;
    end else begin
      modeNow = MODE_SINGLE;
    end
    expanded = modeNow != MODE_SINGLE;
    micro = modeNow == MODE_MICRO;
    narrowBus = busWidthHigh;
    areaIsNarrow = 1'b0;
    case (activeArea)
      2'h1: areaIsNarrow = areaNarrow[0];
      2'h2: areaIsNarrow = areaNarrow[1];
      2'h3: areaIsNarrow = areaNarrow[2];
      default: areaIsNarrow = 1'b0;
    endcase
    accessWide_next = expanded && !narrowBus && !areaIsNarrow;

    sel0 = expanded ? ~p0GpioMask : 8'h00;

    muxPhase = narrowBus && p1MuxAddr && addrPhase;
    sel1 = expanded ? ALL_ON : 8'h00;
    lvl1 = muxPhase ? busAddr[7:0] : busDataOut[7:0];
    oe1 = muxPhase ? ALL_ON : {8{busDataOe}};

    sel2 = (expanded && !narrowBus) ? ALL_ON : 8'h00;

    sel3 = 8'h00;
    sel3[P3_READY] = (modeNow == MODE_EXPAND && p30ReadyOut) || (micro && !p30Gpio);
    sel3[P3_READ] = expanded;
    sel3[P3_LOW_WRITE] = expanded;
    sel3[P3_HIGH_WRITE] = expanded && !narrowBus;
    lvl3 = {4'h0, strobes.highByteWriteStrobeN, strobes.lowByteWriteStrobeN,
            strobes.readN, strobes.readyOutN};
    oe3 = {4'h0, 3'h7, !micro};

    sel4 = expanded ? p4FuncEn : 8'h00;
    if (micro) begin
      sel4[P4_FIXED_LAST:0] = ALL_ON[P4_FIXED_LAST:0];
    end
    lvl4 = {strobes.areaSelectsN, 1'b1, strobes.holdAcknowledgeN, strobes.clockOut,
            strobes.addrLatch};

    // Bus roles override the latches pin by pin.
    pinDrive_next[PORT_ADDR_HI] = mergeBus(dirQ[0], dataQ[0], sel0, busAddr[23:P0_ADDR_BASE],
                                           ALL_ON);
    pinDrive_next[PORT_DATA_LO] = mergeBus(dirQ[1], dataQ[1], sel1, lvl1, oe1);
    pinDrive_next[PORT_DATA_HI] = mergeBus(dirQ[2], dataQ[2], sel2, busDataOut[15:8],
                                           {8{busDataOe}});
    pinDrive_next[PORT_STROBES] = mergeBus(dirQ[3], dataQ[3], sel3, lvl3, oe3);
    pinDrive_next[PORT_CONTROL] = mergeBus(dirQ[4], dataQ[4], sel4, lvl4,
                                           P4_OUTPUT_PINS);

    portRead_next = pinIn;
    busDataIn_next = {pinIn[PORT_DATA_HI], pinIn[PORT_DATA_LO]};
    // An unused ready input reads as ready so accesses are never stretched.
    readyInN_next = (micro && !p30Gpio) ? pinIn[PORT_STROBES][P3_READY] : 1'b0;
    holdReqN_next = sel4[P4_HOLD_REQ] ? pinIn[PORT_CONTROL][P4_HOLD_REQ] : 1'b1;
    modeState_next = modeNow;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinDrive_reg <= '0;
      portRead_reg <= '0;
      busDataIn_reg <= 16'h0000;
      readyInN_reg <= 1'b0;
      holdReqN_reg <= 1'b1;
      accessWide_reg <= 1'b0;
      modeState_reg <= MODE_SINGLE;
    end else begin
      pinDrive_reg <= pinDrive_next;
      portRead_reg <= portRead_next;
      busDataIn_reg <= busDataIn_next;
      readyInN_reg <= readyInN_next;
      holdReqN_reg <= holdReqN_next;
      accessWide_reg <= accessWide_next;
      modeState_reg <= modeState_next;
    end
  end

  assign pinDrive = pinDrive_reg;
  assign portRead = portRead_reg;
  assign busDataIn = busDataIn_reg;
  assign readyInN = readyInN_reg;
  assign holdReqN = holdReqN_reg;
  assign accessWide = accessWide_reg;
  assign modeState = modeState_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Checks skip the first edge after reset, whose sampled past still lies inside reset.
  logic checkLive_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      checkLive_reg <= 1'b0;
    end else begin
      checkLive_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst || !checkLive_reg);

  reset_inputs_a: assert property ($rose(checkLive_reg) &&
    $past(modeState_next) == MODE_SINGLE |->
    pinDrive[0].enable == 8'h00 && pinDrive[4].enable == 8'h00)
    else $error("pins not inputs after reset");
  gpio_direction_a: assert property ($past(modeState_next) == MODE_SINGLE |->
    pinDrive[4].enable == $past(dirQ[4]) && pinDrive[0].level == $past(dataQ[0]))
    else $error("single-chip pin not following latches");
  bus_width_a: assert property ($past(processorModeInput) && $past(busWidthHigh) |->
    !accessWide && pinDrive[2].enable == $past(dirQ[2]))
    else $error("narrow bus still wide");
  area_narrow_a: assert property ($past(processorModeInput) && !$past(busWidthHigh) &&
    $past(activeArea) == 2'h2 |-> accessWide == !$past(areaNarrow[1]))
    else $error("area width wrong");
  p0_address_a: assert property ($past(processorModeInput) && !$past(p0GpioMask[3]) |->
    pinDrive[0].enable[3] && pinDrive[0].level[3] == $past(busAddr[19]))
    else $error("P0 not driving address");
  p1_data_a: assert property ($past(processorModeInput) && !$past(addrPhase) |->
    pinDrive[1].level == $past(busDataOut[7:0]) && pinDrive[1].enable[0] == $past(busDataOe))
    else $error("P1 not carrying data");
  p1_muxaddr_a: assert property ($past(processorModeInput) && $past(busWidthHigh) &&
    $past(p1MuxAddr) && $past(addrPhase) |-> pinDrive[1].level == $past(busAddr[7:0]))
    else $error("P1 low address missing");
  p3_strobes_a: assert property ($past(modeState_next) == MODE_EXPAND |->
    pinDrive[3].level[1] == $past(strobes.readN) && pinDrive[3].enable[2])
    else $error("strobe pins wrong");
  ready_out_a: assert property ($past(modeState_next) == MODE_EXPAND && $past(p30ReadyOut) |->
    pinDrive[3].enable[0] && pinDrive[3].level[0] == $past(strobes.readyOutN))
    else $error("ready output missing");
  ready_in_a: assert property ($past(processorModeInput) && !$past(p30Gpio) |->
    readyInN == $past(pinIn[3][0]) && !pinDrive[3].enable[0])
    else $error("ready input wrong");
  high_write_a: assert property ($past(busWidthHigh) |->
    pinDrive[3].enable[3] == $past(dirQ[3][3]))
    else $error("high write strobe driven on narrow bus");
  p4_default_a: assert property ($past(modeState_next) == MODE_EXPAND && !$past(p4FuncEn[5]) |->
    pinDrive[4].enable[5] == $past(dirQ[4][5]))
    else $error("P4 pin not general I/O");
  p4_fixed_a: assert property ($past(processorModeInput) |->
    pinDrive[4].level[0] == $past(strobes.addrLatch) && !pinDrive[4].enable[3])
    else $error("P4 fixed role missing");

  micro_mode_c: cover property (modeState == MODE_MICRO && accessWide);
  expand_narrow_c: cover property (modeState == MODE_EXPAND && $past(muxPhase));
  single_output_c: cover property (modeState == MODE_SINGLE && pinDrive[0].enable != 8'h00);

endmodule : ext_bus_pin_function_mux

// ===== common/ext_bus_pin_pkg.sv
// Shared types and constants of the external bus pin-function multiplexer.
// Assumes one clock domain and pins resolved outside the design from level and enable.
package ext_bus_pin_pkg;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int PORT_COUNT = 5;
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ALL_ON = 8'hff;

  // ----------------------------------------------------------------------
  // Port indices and pin positions
  // ----------------------------------------------------------------------
  localparam int PORT_ADDR_HI = 0;
  localparam int PORT_DATA_LO = 1;
  localparam int PORT_DATA_HI = 2;
  localparam int PORT_STROBES = 3;
  localparam int PORT_CONTROL = 4;
  localparam int P0_ADDR_BASE = 16;
  localparam int P3_READY = 0;
  localparam int P3_READ = 1;
  localparam int P3_LOW_WRITE = 2;
  localparam int P3_HIGH_WRITE = 3;
  localparam int P4_HOLD_REQ = 3;
  localparam int P4_FIXED_LAST = 4;
  localparam logic [7:0] P4_OUTPUT_PINS = 8'hf7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [PORT_WIDTH-1:0] port_bits_t;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXPAND = 2'b01,
    MODE_MICRO = 2'b11
  } mode_t;

  typedef struct packed {
    port_bits_t level;
    port_bits_t enable;
  } pin_drive_t;

  // Strobes of the bus unit; names ending in N are active low.
  typedef struct packed {
    logic readN;
    logic lowByteWriteStrobeN;
    logic highByteWriteStrobeN;
    logic addrLatch;
    logic clockOut;
    logic holdAcknowledgeN;
    logic readyOutN;
    logic [3:0] areaSelectsN;
  } bus_strobe_t;

endpackage : ext_bus_pin_pkg

// ===== hdl/gpio_port_regs.sv
// Direction and data latches of one 8-bit general I/O port.
// Assumes write strobes are one-cycle pulses synchronous to mclk.
`timescale 1ns/1ps
module gpio_port_regs
  import ext_bus_pin_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dirWe,
  input wire logic dataWe,
  input wire port_bits_t wrData,
  output port_bits_t dirQ,
  output port_bits_t dataQ
);

  port_bits_t dir_reg, dir_next;
  port_bits_t data_reg, data_next;

  always_comb begin
    dir_next = dirWe ? wrData : dir_reg;
    data_next = dataWe ? wrData : data_reg;
  end

  // Every pin is an input after reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dir_reg <= DIR_RESET;
      data_reg <= DATA_RESET;
    end else begin
      dir_reg <= dir_next;
      data_reg <= data_next;
    end
  end

  assign dirQ = dir_reg;
  assign dataQ = data_reg;

endmodule : gpio_port_regs

// ===== bench/ext_bus_partner.sv
// Model of the memory and peripherals on the far side of the expansion bus.
// Assumes pinDrive comes from the multiplexer and ready and hold levels from the bench.
`timescale 1ns/1ps
module ext_bus_partner
  import ext_bus_pin_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire pin_drive_t [4:0] pinDrive,
  input wire logic readyLevel,
  input wire logic holdLevel,
  output port_bits_t [4:0] pinIn
);
  // ----------------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------------
  // Released lines other than ready, hold and read data toggle every cycle, so a stale value never passes for data.
  port_bits_t alt;
  port_bits_t ext [5];
  logic reading;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alt <= 8'h55;
    end else begin
      alt <= ~alt;
    end
  end

  always_comb begin
    reading = pinDrive[3].enable[1] && !pinDrive[3].level[1];
    for (int p = 0; p < 5; p++) begin
      ext[p] = alt;
    end
    if (reading) begin
      ext[1] = 8'h3c;
      ext[2] = 8'hc3;
    end
    ext[3][0] = readyLevel;
    ext[4][3] = holdLevel;
    for (int p = 0; p < 5; p++) begin
      pinIn[p] = (pinDrive[p].enable & pinDrive[p].level) | (~pinDrive[p].enable & ext[p]);
    end
  end
endmodule : ext_bus_partner

// ===== bench/tb_top.sv
// Self-checking bench of the pin-function multiplexer.
// Assumes the partner model resolves every pin from both sides.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tb_top
  import ext_bus_pin_pkg::*;
;
  // ----------------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------------
  logic mclk, nrst, processorModeInput, expandEnable, busWidthHigh, p1MuxAddr, addrPhase;
  logic p30ReadyOut, p30Gpio, busDataOe, readyLevel, holdLevel, readyInN, holdReqN, accessWide;
  logic [2:0] areaNarrow;
  logic [1:0] activeArea;
  logic [4:0] dirWe, dataWe;
  logic [23:0] busAddr;
  logic [15:0] busDataOut, busDataIn;
  port_bits_t p0GpioMask, p4FuncEn, wrData;
  port_bits_t [4:0] pinIn, portRead;
  pin_drive_t [4:0] pinDrive;
  bus_strobe_t strobes;
  mode_t modeState;
  int n_fail, n_tests;

  ext_bus_pin_function_mux u_ext_bus_pin_function_mux (.mclk, .nrst, .processorModeInput,
    .expandEnable, .busWidthHigh, .areaNarrow, .activeArea, .p0GpioMask, .p1MuxAddr,
    .addrPhase, .p30ReadyOut, .p30Gpio, .p4FuncEn, .dirWe, .dataWe, .wrData, .busAddr,
    .busDataOut, .busDataOe, .strobes, .pinIn, .pinDrive, .portRead, .busDataIn, .readyInN,
    .holdReqN, .accessWide, .modeState);
  ext_bus_partner u_ext_bus_partner (.mclk, .nrst, .pinDrive, .readyLevel, .holdLevel, .pinIn);

  always #20 mclk = ~mclk;

  // Three edges cover the latch path, the output register and the read-back register.
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task wr(input int p);
    @(posedge mclk);
    dirWe[p] <= 1'b1;
    wrData <= 8'h3c;
    @(posedge mclk);
    dirWe[p] <= 1'b0;
    dataWe[p] <= 1'b1;
    wrData <= 8'ha5;
    @(posedge mclk);
    dataWe[p] <= 1'b0;
  endtask : wr

  task set_mode(input logic md, input logic ex, input logic bw);
    @(posedge mclk);
    processorModeInput <= md;
    expandEnable <= ex;
    busWidthHigh <= bw;
  endtask : set_mode

  task t_reset;
    for (int p = 0; p < 5; p++) `CHK(pinDrive[p].enable, 8'h00)
    `CHK(modeState, MODE_SINGLE)
  endtask : t_reset

  task t_single;
    for (int p = 0; p < 5; p++) wr(p);
    settle;
    for (int p = 0; p < 5; p++) begin
      `CHK(pinDrive[p], {8'ha5, 8'h3c})
      `CHK(portRead[p] & 8'h3c, 8'h24)
    end
  endtask : t_single

  task t_micro16;
    set_mode(1'b1, 1'b0, 1'b0);
    busAddr <= 24'habcdef;
    p0GpioMask <= 8'h0f;
    busDataOut <= 16'h1234;
    busDataOe <= 1'b1;
    strobes <= 11'h53f;
    readyLevel <= 1'b1;
    settle;
    `CHK(modeState, MODE_MICRO)
    `CHK(pinDrive[0], {8'ha5, 8'hfc})
    `CHK(pinDrive[1], {8'h34, 8'hff})
    `CHK(pinDrive[2], {8'h12, 8'hff})
    `CHK(accessWide, 1'b1)
    `CHK(pinDrive[3].enable[3:0], 4'he)
    `CHK(pinDrive[3].level[3:1], 3'b101)
    `CHK(readyInN, 1'b1)
    `CHK(pinDrive[4].enable, 8'h37)
    `CHK(pinDrive[4].level[2:0], 3'b100)
    @(posedge mclk);
    busDataOe <= 1'b0;
    strobes.readN <= 1'b0;
    p30Gpio <= 1'b1;
    areaNarrow <= 3'b010;
    activeArea <= 2'd2;
    settle;
    `CHK(busDataIn, 16'hc33c)
    `CHK(readyInN, 1'b0)
    `CHK(accessWide, 1'b0)
    @(posedge mclk);
    activeArea <= 2'd3;
    settle;
    `CHK(accessWide, 1'b1)
  endtask : t_micro16

  task t_micro8;
    set_mode(1'b1, 1'b0, 1'b1);
    strobes.readN <= 1'b1;
    busDataOe <= 1'b1;
    p30Gpio <= 1'b0;
    p1MuxAddr <= 1'b1;
    addrPhase <= 1'b1;
    settle;
    `CHK(accessWide, 1'b0)
    `CHK(pinDrive[2], {8'ha5, 8'h3c})
    `CHK(pinDrive[3].enable[3], 1'b1)
    `CHK(pinDrive[3].level[3], 1'b0)
    `CHK(pinDrive[1], {8'hef, 8'hff})
    @(posedge mclk);
    addrPhase <= 1'b0;
    settle;
    `CHK(pinDrive[1], {8'h34, 8'hff})
  endtask : t_micro8

  task t_expand;
    set_mode(1'b0, 1'b1, 1'b0);
    holdLevel <= 1'b0;
    settle;
    `CHK(modeState, MODE_EXPAND)
    `CHK(pinDrive[3].enable[3:0], 4'he)
    `CHK(pinDrive[4], {8'ha5, 8'h3c})
    `CHK(holdReqN, 1'b1)
    @(posedge mclk);
    p30ReadyOut <= 1'b1;
    strobes.readyOutN <= 1'b0;
    p4FuncEn <= 8'hff;
    settle;
    `CHK(pinDrive[3].enable[0], 1'b1)
    `CHK(pinDrive[3].level[0], 1'b0)
    `CHK(pinDrive[4].enable, 8'hf7)
    `CHK(pinDrive[4].level, 8'hfc)
    `CHK(holdReqN, 1'b0)
  endtask : t_expand

  task t_rereset;
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    #1;
    for (int p = 0; p < 5; p++) `CHK(pinDrive[p].enable, 8'h00)
    @(posedge mclk);
    nrst <= 1'b1;
    settle;
    `CHK(modeState, MODE_EXPAND)
    `CHK(pinDrive[0].enable, 8'hf0)
  endtask : t_rereset

  task conclude;
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {mclk, nrst, processorModeInput, expandEnable, busWidthHigh, p1MuxAddr, addrPhase} = '0;
    {p30ReadyOut, p30Gpio, busDataOe, readyLevel, holdLevel, areaNarrow, activeArea} = '0;
    {dirWe, dataWe, busAddr, busDataOut, p0GpioMask, p4FuncEn, wrData} = '0;
    strobes = 11'h73f;
    n_fail = 0;
    n_tests = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    t_reset;
    t_single;
    t_micro16;
    t_micro8;
    t_expand;
    t_rereset;
    conclude;
  end

  // A hung run counts as a mismatch.
  initial begin
    #1000000;
    n_fail++;
    conclude;
  end
endmodule : tb_top
